// File: rtl/tplps_top.sv
// Twisted-pair link integrity, receive polarity correction and LED status logic.
// Assumes port status inputs come from logic on pclk; the attribute select pins and
// the management serial input strap arrive from outside and are treated as pins.
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns

// Notes on behaviour
// - Link pulse after 8-17 ms transmit idle.
// - Silent 65-132 ms with test on: link-fail.
// - Link-fail blocks port; four pulses or packet recover.
// - Link test disabled never enters link-fail.
// - Pulses gated only by own enable.
// - Negative delimiter inverts receive polarity when enabled.
// - Polarity decided once per reset or fail.
// - Serial input strap sets polarity default.
// - Twelve outputs: two banks plus globals.
// - Output driven low only while attribute true.
// - Blinking attribute wins over solid one.
// - Codes 000/001 map link, partition, carrier.
// - Code 110 link solid, activity 130 ms blink.
// - Code 101 blinks all 16 times first.
// - Code 111 holds all on 4 s first.
// - Override enables drive whole bank low; the code drives the bank at the override rate, so it stays dark at rate off.
// - Override rate off, 512, 1560 or on.
// - Carrier, collision stretched 4 ms; 111: collision 100 us.
// - Loopback sampled at frame end, starts false.
// - Loopback false on error, disable, reverse mode.
module tplps_top #(
  parameter int unsigned TICK_CYC = tplps_pkg::TICK_CYC_DEF
) (
  // APB clock, reset and slave port.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tplps_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins: management serial input strap and LED attribute select.
  input wire logic mgmt_serial_in,
  input wire logic [2:0] led_attribute_select,
  // Twisted-pair port activity from the transceivers.
  input wire logic [4:1] tx_active,
  input wire logic [4:1] rx_link_pulse,
  input wire logic [4:1] rx_packet,
  input wire logic [4:1] rx_frame_end,
  input wire logic [4:1] end_of_frame_delimiter,
  // Per-port status, index 0 is the AUI port.
  input wire logic [4:0] carrier,
  input wire logic [4:0] collision,
  input wire logic [4:0] partitioned,
  input wire logic [4:0] port_disabled,
  input wire logic jabber,
  // AUI loopback sensing.
  input wire logic aui_reverse,
  input wire logic aui_frame_end,
  input wire logic aui_tx_carrier,
  input wire logic aui_loop_error,
  // Link and polarity results.
  output logic [4:1] link_pulse_send,
  output logic [4:1] link_fail,
  output logic [4:1] rx_invert,
  // Open-drain LED enables; high means the pin is pulled low.
  output logic [4:0] bank_a_port_led_oe,
  output logic [4:0] bank_b_port_led_oe,
  output logic global_led_a_oe,
  output logic global_led_b_oe
);
  import tplps_pkg::*;

  // Refuse a time base the 16-bit tick counter cannot hold.
  if (TICK_CYC < 1 || TICK_CYC > 65535) begin : g_bad_tick
    $error("TICK_CYC out of range");
  end

  // ----------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------
  logic [15:0] tick_cnt_r; // Cycle count within one tick.
  logic tick_r; // One-cycle pulse every tick.

  // Divides pclk down to the common tick.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_r <= 16'h0000;
      tick_r <= 1'b0;
    end else if (tick_cnt_r == 16'(TICK_CYC - 1)) begin
      tick_cnt_r <= 16'h0000;
      tick_r <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 16'h0001;
      tick_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] ldc_s1_r, ldc_s2_r, ldc_s3_r; // Three-stage select synchroniser.
  logic [2:0] ldc_fill_r; // Marks the stages that hold a pin sample since reset.
  logic ldc_ok_r; // High once the selection reflects the pins.
  tplps_ldc_e ldc_r; // Accepted attribute selection.
  logic strap_pend_r; // High until the strap has been taken.

  // Samples the select pins; a change counts once stages two and three agree.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ldc_s1_r <= 3'h0;
      ldc_s2_r <= 3'h0;
      ldc_s3_r <= 3'h0;
      ldc_fill_r <= 3'h0;
      ldc_ok_r <= 1'b0;
      ldc_r <= LDC_PAR;
    end else begin
      ldc_s1_r <= led_attribute_select;
      ldc_s2_r <= ldc_s1_r;
      ldc_s3_r <= ldc_s2_r;
      ldc_fill_r <= {ldc_fill_r[1:0], 1'b1};
      // Reset values in the stages are no pin samples, so they are never taken.
      if (ldc_fill_r[2] && ldc_s2_r == ldc_s3_r) begin
        ldc_r <= tplps_ldc_e'(ldc_s3_r);
        ldc_ok_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // APB slave and registers
  // ----------------------------------------------------------------
  logic ovr_a_r, ovr_b_r; // Bank override enables.
  tplps_ovr_e ovr_rate_r; // Last issued override blink rate.
  logic [4:1] lt_en_r, lp_en_r, pol_en_r; // Per-port link test, pulse, polarity enables.
  logic loop_ok_r; // AUI loopback good.
  logic setup_w, access_w, mapped_w;

  assign setup_w = psel && !penable;
  assign access_w = psel && penable && pready;
  assign mapped_w = (paddr == ADDR_OVR_CTRL) || (paddr == ADDR_OVR_RATE) || (paddr == ADDR_LT_EN) ||
                    (paddr == ADDR_LP_EN) || (paddr == ADDR_POL_EN) || (paddr == ADDR_STATUS);

  // Answers in the first cycle of the access phase with registered data.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (setup_w) begin
      pready <= 1'b1;
      pslverr <= !mapped_w;
      prdata <= 32'h0000_0000;
      if (!pwrite) begin
        if (paddr == ADDR_OVR_CTRL) begin
          prdata[OVR_A_BIT] <= ovr_a_r;
          prdata[OVR_B_BIT] <= ovr_b_r;
        end else if (paddr == ADDR_OVR_RATE) begin
          prdata[1:0] <= ovr_rate_r;
        end else if (paddr == ADDR_LT_EN) begin
          prdata[TP_MSB:TP_LSB] <= lt_en_r;
        end else if (paddr == ADDR_LP_EN) begin
          prdata[TP_MSB:TP_LSB] <= lp_en_r;
        end else if (paddr == ADDR_POL_EN) begin
          prdata[TP_MSB:TP_LSB] <= pol_en_r;
        end else if (paddr == ADDR_STATUS) begin
          prdata[ST_FAIL_LSB+3:ST_FAIL_LSB] <= link_fail;
          prdata[ST_INV_LSB+3:ST_INV_LSB] <= rx_invert;
          prdata[ST_LOOP_BIT] <= loop_ok_r;
        end
      end
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Software-written control; polarity enables take the strap just after reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovr_a_r <= 1'b0;
      ovr_b_r <= 1'b0;
      ovr_rate_r <= OVR_OFF;
      lt_en_r <= LT_EN_RST;
      lp_en_r <= LP_EN_RST;
      pol_en_r <= 4'h0;
      strap_pend_r <= 1'b1;
    end else begin
      strap_pend_r <= 1'b0;
      if (strap_pend_r) begin
        pol_en_r <= {4{!mgmt_serial_in}};
      end
      if (access_w && pwrite) begin
        if (paddr == ADDR_OVR_CTRL) begin
          ovr_a_r <= pwdata[OVR_A_BIT];
          ovr_b_r <= pwdata[OVR_B_BIT];
        end else if (paddr == ADDR_OVR_RATE) begin
          ovr_rate_r <= tplps_ovr_e'(pwdata[1:0]);
        end else if (paddr == ADDR_LT_EN) begin
          lt_en_r <= pwdata[TP_MSB:TP_LSB];
        end else if (paddr == ADDR_LP_EN) begin
          lp_en_r <= pwdata[TP_MSB:TP_LSB];
        end else if (paddr == ADDR_POL_EN && !strap_pend_r) begin
          pol_en_r <= pwdata[TP_MSB:TP_LSB];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Twisted-pair link monitor and polarity, one instance per port
  // ----------------------------------------------------------------
  for (genvar p = 1; p <= 4; p++) begin : g_tp
    logic [15:0] idle_cnt_r; // Ticks since the transmitter was last active or the last pulse interval ended.
    logic [15:0] silent_cnt_r; // Ticks since the last pulse, packet or silent timeout.
    logic [2:0] pulse_cnt_r; // Consecutive pulses seen while failed.
    logic pol_done_r; // Polarity decision already made.
    logic silent_w;

    assign silent_w = silent_cnt_r >= LF_TICKS;

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        idle_cnt_r <= 16'h0000;
        link_pulse_send[p] <= 1'b0;
      end else if (tx_active[p]) begin
        idle_cnt_r <= 16'h0000;
        link_pulse_send[p] <= 1'b0;
      end else if (idle_cnt_r >= LP_TICKS) begin
        idle_cnt_r <= 16'h0000;
        link_pulse_send[p] <= lp_en_r[p];
      end else begin
        idle_cnt_r <= idle_cnt_r + {15'h0000, tick_r};
        link_pulse_send[p] <= 1'b0;
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        silent_cnt_r <= 16'h0000;
      end else if (rx_link_pulse[p] || rx_packet[p] || silent_w) begin
        silent_cnt_r <= 16'h0000;
      end else begin
        silent_cnt_r <= silent_cnt_r + {15'h0000, tick_r};
      end
    end

    // Ports start failed; a silent timeout breaks a run of pulses.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        link_fail[p] <= 1'b1;
        pulse_cnt_r <= 3'h0;
      end else if (!lt_en_r[p]) begin
        link_fail[p] <= 1'b0;
        pulse_cnt_r <= 3'h0;
      end else if (!link_fail[p]) begin
        // Activity in the timeout cycle still counts as heard.
        link_fail[p] <= silent_w && !rx_link_pulse[p] && !rx_packet[p];
        pulse_cnt_r <= 3'h0;
      end else if (rx_packet[p]) begin
        link_fail[p] <= 1'b0;
        pulse_cnt_r <= 3'h0;
      end else if (silent_w) begin
        pulse_cnt_r <= 3'h0;
      end else if (rx_link_pulse[p]) begin
        if (pulse_cnt_r == LINK_UP_CNT - 3'h1) begin
          link_fail[p] <= 1'b0;
          pulse_cnt_r <= 3'h0;
        end else begin
          pulse_cnt_r <= pulse_cnt_r + 3'h1;
        end
      end
    end

    // Decides the receive polarity on the first frame end after reset or link-fail.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        rx_invert[p] <= 1'b0;
        pol_done_r <= 1'b0;
      end else if (link_fail[p]) begin
        rx_invert[p] <= 1'b0;
        pol_done_r <= 1'b0;
      end else if (rx_frame_end[p] && pol_en_r[p] && !pol_done_r) begin
        rx_invert[p] <= end_of_frame_delimiter[p];
        pol_done_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Blink generators and start-up display
  // ----------------------------------------------------------------
  logic [BLK_N-1:0] blink; // Blink phase per period, high while lit.
  logic [15:0] start_cnt_r; // Ticks since the selection was taken, until start-up ends.
  logic start_done_r; // Start-up display finished.

  for (genvar b = 0; b < BLK_N; b++) begin : g_blk
    logic [15:0] half_cnt_r;

    // Toggles the phase every half period; starts lit after reset.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        half_cnt_r <= 16'h0000;
        blink[b] <= 1'b1;
      end else if (tick_r && half_cnt_r == BLK_HALF[b] - 16'h0001) begin
        half_cnt_r <= 16'h0000;
        blink[b] <= !blink[b];
      end else begin
        half_cnt_r <= half_cnt_r + {15'h0000, tick_r};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_cnt_r <= 16'h0000;
      start_done_r <= 1'b0;
    end else if (!start_done_r && ldc_ok_r) begin
      // Waits for the synchronised code, so the reset value cannot end the display.
      start_cnt_r <= start_cnt_r + {15'h0000, tick_r};
      if ((ldc_r == LDC_STARTBLK && start_cnt_r >= START_BLK_TICKS) ||
          (ldc_r == LDC_STARTON && start_cnt_r >= START_ON_TICKS) ||
          (ldc_r != LDC_STARTBLK && ldc_r != LDC_STARTON)) begin
        start_done_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Carrier and collision stretching, AUI loopback
  // ----------------------------------------------------------------
  logic [4:0] crs_x, col_x; // Stretched indications per port.

  for (genvar s = 0; s < 5; s++) begin : g_str
    logic [15:0] crs_cnt_r, col_cnt_r;

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        crs_cnt_r <= 16'h0000;
        col_cnt_r <= 16'h0000;
      end else begin
        if (carrier[s]) begin
          crs_cnt_r <= STRETCH_TICKS;
        end else if (crs_cnt_r != 16'h0000) begin
          crs_cnt_r <= crs_cnt_r - {15'h0000, tick_r};
        end
        if (collision[s]) begin
          col_cnt_r <= (ldc_r == LDC_STARTON) ? COL_SHORT_TICKS : STRETCH_TICKS;
        end else if (col_cnt_r != 16'h0000) begin
          col_cnt_r <= col_cnt_r - {15'h0000, tick_r};
        end
      end
    end

    assign crs_x[s] = carrier[s] || crs_cnt_r != 16'h0000;
    assign col_x[s] = collision[s] || col_cnt_r != 16'h0000;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loop_ok_r <= 1'b0;
    end else if (aui_loop_error || port_disabled[0] || aui_reverse) begin
      loop_ok_r <= 1'b0;
    end else if (aui_frame_end) begin
      loop_ok_r <= aui_tx_carrier;
    end
  end

  // ----------------------------------------------------------------
  // LED attribute selection
  // ----------------------------------------------------------------
  logic [4:0] a_nxt, b_nxt; // Bank outputs, high means lit.
  logic ga_nxt, gb_nxt; // Global outputs, high means lit.
  logic [4:0] link_up; // Link good per port; AUI has no link.
  logic ovr_lit; // Override blink phase.

  assign link_up = {~link_fail, 1'b0};

  always_comb begin
    case (ovr_rate_r)
      OVR_OFF: ovr_lit = 1'b0;
      OVR_512: ovr_lit = blink[BLK_I512];
      OVR_1560: ovr_lit = blink[BLK_I1560];
      default: ovr_lit = 1'b1;
    endcase
  end

  always_comb begin
    ga_nxt = |crs_x;
    gb_nxt = |col_x;
    a_nxt = 5'h00;
    b_nxt = 5'h00;
    case (ldc_r)
      LDC_PAR: begin
        a_nxt = link_up & ~partitioned;
        a_nxt[0] = loop_ok_r;
        b_nxt = partitioned;
      end
      LDC_CRS: begin
        a_nxt = link_up;
        a_nxt[0] = loop_ok_r;
        b_nxt = crs_x;
      end
      LDC_BLK260: begin
        ga_nxt = (|crs_x) & blink[BLK_I260];
        gb_nxt = (|col_x) & blink[BLK_I260];
        for (int i = 0; i < 5; i++) begin
          a_nxt[i] = crs_x[i] ? blink[BLK_I260] : link_up[i];
          b_nxt[i] = col_x[i] ? blink[BLK_I260] : partitioned[i];
        end
      end
      LDC_STARTBLK: begin
        ga_nxt = |col_x;
        gb_nxt = jabber;
        for (int i = 0; i < 5; i++) begin
          a_nxt[i] = crs_x[i] ? blink[BLK_I512] : link_up[i];
        end
        b_nxt = partitioned;
      end
      LDC_ACT130: begin
        for (int i = 0; i < 5; i++) begin
          a_nxt[i] = crs_x[i] ? blink[BLK_I130] : (link_up[i] || partitioned[i]);
        end
        b_nxt = partitioned | port_disabled;
      end
      LDC_STARTON: begin
        for (int i = 0; i < 5; i++) begin
          a_nxt[i] = partitioned[i] ? blink[BLK_I1560] : link_up[i];
        end
        b_nxt = col_x;
        b_nxt[0] = partitioned[0];
      end
      default: begin
        ga_nxt = 1'b0;
        gb_nxt = 1'b0;
      end
    endcase
    if (!start_done_r && ldc_r == LDC_STARTBLK) begin
      {ga_nxt, gb_nxt, a_nxt, b_nxt} = {12{blink[BLK_I260]}};
    end else if (!start_done_r && ldc_r == LDC_STARTON) begin
      {ga_nxt, gb_nxt, a_nxt, b_nxt} = 12'hFFF;
    end
    if (ovr_a_r) begin
      {ga_nxt, a_nxt} = {6{ovr_lit}};
    end
    if (ovr_b_r) begin
      {gb_nxt, b_nxt} = {6{ovr_lit}};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_a_port_led_oe <= 5'h00;
      bank_b_port_led_oe <= 5'h00;
      global_led_a_oe <= 1'b0;
      global_led_b_oe <= 1'b0;
    end else begin
      bank_a_port_led_oe <= a_nxt;
      bank_b_port_led_oe <= b_nxt;
      global_led_a_oe <= ga_nxt;
      global_led_b_oe <= gb_nxt;
    end
  end

endmodule

// File: rtl/tplps_pkg.sv
// Constants shared by the twisted-pair link, polarity and LED status block.
// Assumes a 50 MHz pclk and a 100 us internal time base derived from it.
package tplps_pkg;

  // ----------------------------------------------------------------
  // Clock and time base
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned TICK_US = 100;
  localparam int unsigned TICK_CYC_DEF = TICK_US * 1000 / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Times as printed, in microseconds
  // ----------------------------------------------------------------
  localparam int unsigned LP_IDLE_MIN_US = 8000;
  localparam int unsigned LP_IDLE_MAX_US = 17000;
  localparam int unsigned LF_SILENT_MIN_US = 65000;
  localparam int unsigned LF_SILENT_MAX_US = 132000;
  localparam int unsigned BLK130_US = 130000;
  localparam int unsigned BLK260_US = 260000;
  localparam int unsigned BLK512_US = 512000;
  localparam int unsigned BLK1560_US = 1560000;
  localparam int unsigned STRETCH_US = 4000;
  localparam int unsigned COL_SHORT_US = 100;
  localparam int unsigned START_ON_US = 4000000;
  localparam int unsigned START_BLINKS = 16;
  localparam int unsigned LINK_UP_PULSES = 4;

  // ----------------------------------------------------------------
  // Derived counts in ticks; least times round up by one extra tick
  // ----------------------------------------------------------------
  localparam logic [15:0] LP_TICKS = 16'(LP_IDLE_MIN_US / TICK_US + 1);
  localparam logic [15:0] LF_TICKS = 16'(LF_SILENT_MIN_US / TICK_US + 1);
  localparam logic [15:0] STRETCH_TICKS = 16'(STRETCH_US / TICK_US + 1);
  localparam logic [15:0] COL_SHORT_TICKS = 16'(COL_SHORT_US / TICK_US + 1);
  localparam logic [15:0] START_ON_TICKS = 16'(START_ON_US / TICK_US);
  localparam logic [15:0] START_BLK_TICKS = 16'(START_BLINKS * BLK260_US / TICK_US);
  localparam logic [2:0] LINK_UP_CNT = 3'(LINK_UP_PULSES);

  // Blink generator index and half periods in ticks.
  localparam int unsigned BLK_N = 4;
  localparam int unsigned BLK_I130 = 0;
  localparam int unsigned BLK_I260 = 1;
  localparam int unsigned BLK_I512 = 2;
  localparam int unsigned BLK_I1560 = 3;
  localparam logic [15:0] BLK_HALF [BLK_N] = '{16'(BLK130_US / 2 / TICK_US), 16'(BLK260_US / 2 / TICK_US),
                                                16'(BLK512_US / 2 / TICK_US), 16'(BLK1560_US / 2 / TICK_US)};

  // ----------------------------------------------------------------
  // APB register map (byte addresses) and fields
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] ADDR_OVR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_OVR_RATE = 12'h004;
  localparam logic [11:0] ADDR_LT_EN = 12'h008;
  localparam logic [11:0] ADDR_LP_EN = 12'h00C;
  localparam logic [11:0] ADDR_POL_EN = 12'h010;
  localparam logic [11:0] ADDR_STATUS = 12'h014;
  localparam int unsigned OVR_A_BIT = 0;
  localparam int unsigned OVR_B_BIT = 1;
  localparam int unsigned TP_LSB = 1;
  localparam int unsigned TP_MSB = 4;
  localparam int unsigned ST_FAIL_LSB = 1;
  localparam int unsigned ST_INV_LSB = 9;
  localparam int unsigned ST_LOOP_BIT = 16;
  localparam logic [3:0] LT_EN_RST = 4'hF;
  localparam logic [3:0] LP_EN_RST = 4'hF;

  // LED attribute selection codes.
  typedef enum logic [2:0] {
    LDC_PAR = 3'h0, LDC_CRS = 3'h1, LDC_RSV2 = 3'h2, LDC_RSV3 = 3'h3,
    LDC_BLK260 = 3'h4, LDC_STARTBLK = 3'h5, LDC_ACT130 = 3'h6, LDC_STARTON = 3'h7
  } tplps_ldc_e;

  // Software override blink rates.
  typedef enum logic [1:0] {
    OVR_OFF = 2'h0, OVR_512 = 2'h1, OVR_1560 = 2'h2, OVR_ON = 2'h3
  } tplps_ovr_e;

endpackage

// File: test/tplps_partner.sv
// Link partner model for the four twisted-pair ports.
// Assumes the bench calls its tasks between clock edges.
`timescale 1ns/1ns
module tplps_partner (
  // Clock.
  input wire logic pclk,
  // Receive events toward the block.
  output logic [4:1] rx_link_pulse,
  output logic [4:1] rx_packet,
  output logic [4:1] rx_frame_end,
  output logic [4:1] end_of_frame_delimiter
);
  initial begin
    rx_link_pulse = '0;
    rx_packet = '0;
    rx_frame_end = '0;
    end_of_frame_delimiter = '0;
  end
  // Sends n link pulses with gap+1 idle cycles between them, so slow partners are seen too.
  task automatic pulses(input int p, input int n, input int gap);
    repeat (n) begin
      @(posedge pclk);
      rx_link_pulse[p] <= 1'b1;
      @(posedge pclk);
      rx_link_pulse[p] <= 1'b0;
      repeat (gap) @(posedge pclk);
    end
  endtask
  // Sends a packet and its end; the delimiter is inverted after the end.
  task automatic frame(input int p, input logic neg);
    @(posedge pclk);
    rx_packet[p] <= 1'b1;
    @(posedge pclk);
    rx_packet[p] <= 1'b0;
    rx_frame_end[p] <= 1'b1;
    end_of_frame_delimiter[p] <= neg;
    @(posedge pclk);
    rx_frame_end[p] <= 1'b0;
    end_of_frame_delimiter[p] <= ~neg;
  endtask
endmodule

// File: test/tplps_top_assertions.sv
// Port-level properties of the link and polarity logic.
// Assumes it is bound to tplps_top.
`timescale 1ns/1ns
module tplps_top_assertions (
  // Clock, reset and APB handshake.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // Link events and results.
  input wire logic [4:1] tx_active,
  input wire logic [4:1] rx_link_pulse,
  input wire logic [4:1] rx_packet,
  input wire logic [4:1] rx_frame_end,
  input wire logic [4:1] end_of_frame_delimiter,
  input wire logic [4:1] link_pulse_send,
  input wire logic [4:1] link_fail,
  input wire logic [4:1] rx_invert
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  apb_ready_a: assert property (psel && !penable |=> pready) else $error("no ready after setup");
  rst_fail_a: assert property ($rose(presetn) |-> link_fail == 4'hF)
    else $error("ports not failed at reset");
  recover_a: assert property (|(link_fail & rx_packet) |=> !(|(link_fail & $past(rx_packet))))
    else $error("packet did not recover link");
  pulse_single_a: assert property (|link_pulse_send |=> !(|(link_pulse_send & $past(link_pulse_send))))
    else $error("link pulse longer than one cycle");
  pulse_idle_a: assert property (|tx_active |=> !(|(link_pulse_send & $past(tx_active))))
    else $error("link pulse while transmitting");
  fail_silent_a: assert property (!(|(link_fail & ~$past(link_fail) & $past(rx_packet | rx_link_pulse))))
    else $error("link fail right after activity");
  inv_cause_a: assert property (!(|(rx_invert & ~$past(rx_invert) & ~$past(rx_frame_end & end_of_frame_delimiter))))
    else $error("polarity inverted without negative delimiter");
  inv_hold_a: assert property (!(|(~rx_invert & $past(rx_invert) & ~$past(link_fail))))
    else $error("polarity changed without link fail");
  cover property (link_pulse_send[1]);
  cover property ($fell(link_fail[1]));
  cover property ($rose(rx_invert[1]));
endmodule
bind tplps_top tplps_top_assertions chk (.*);

// File: test/tplps_top_tb.sv
// Self-checking bench for the link, polarity and LED status block.
// Assumes the partner model drives receive events.
`timescale 1ns/1ns
module tplps_top_tb;
  import tplps_pkg::*;
  localparam int unsigned TC = 5;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, mgmt_serial_in = 0;
  logic pready, pslverr, jabber = 0, aui_reverse = 0, aui_frame_end = 0, aui_tx_carrier = 0, aui_loop_error = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [2:0] sel = 3'h0;
  logic [4:1] tx_active = 4'h2, rx_link_pulse, rx_packet, rx_frame_end, eofd, link_pulse_send, link_fail, rx_invert;
  logic [4:0] carrier = '0, collision = '0, partitioned = '0, port_disabled = '0, la, lb;
  logic gla, glb;
  logic [32:0] expq[$];
  int miscompares = 0, checked = 0, n, p1 = 0, p2 = 0;
  always #10 pclk = ~pclk;
  tplps_top #(.TICK_CYC(TC)) uut (.*, .led_attribute_select(sel), .end_of_frame_delimiter(eofd),
    .bank_a_port_led_oe(la), .bank_b_port_led_oe(lb), .global_led_a_oe(gla), .global_led_b_oe(glb));
  tplps_partner lp (.*, .end_of_frame_delimiter(eofd));
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // One APB transfer; waits for ready under a bound.
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) miscompares++;
    if (n >= 40) tally_and_finish();
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    expq.push_back(e);
    apb(a, 1'b0, 32'h0);
  endtask
  // Read results are compared with the oldest note.
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) chk({pslverr, prdata}, expq.pop_front());
    p1 += 32'(link_pulse_send[1]);
    p2 += 32'(link_pulse_send[2]);
  end
  initial begin
    void'($urandom(67912));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    rd(ADDR_LT_EN, 33'h1E);
    rd(ADDR_POL_EN, 33'h1E);
    rd(ADDR_STATUS, 33'h1E);
    rd(12'h018, 33'h1_0000_0000);
    $display("Register reset test done");
    n = 0;
    while (link_pulse_send[1] !== 1'b1 && n < 500) begin
      @(posedge pclk);
      n++;
    end
    chk(33'(n >= 360 && n <= 420 && p2 == 0), 33'h1);
    if (n >= 500) tally_and_finish();
    lp.pulses(1, 4, $urandom_range(1, 20));
    lp.pulses(3, 3, 0);
    lp.frame(2, 1'b0);
    lp.frame(2, 1'b0);
    lp.frame(1, 1'b1);
    lp.frame(2, 1'b1);
    repeat (2) @(posedge pclk);
    chk(33'({link_fail, rx_invert}), 33'hC1);
    apb(ADDR_LT_EN, 1'b1, 32'h1C);
    p1 = 0;
    repeat (700 * TC) @(posedge pclk);
    chk(33'({link_fail, p1 > 4}), 33'h1D);
    rd(ADDR_STATUS, 33'h21C);
    $display("Link and polarity test done");
    partitioned <= 5'($urandom());
    aui_tx_carrier <= 1'b1;
    aui_frame_end <= 1'b1;
    @(posedge pclk);
    aui_frame_end <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(33'({la, lb, gla, glb}), 33'({4'h1 & ~partitioned[4:1], 1'b1, partitioned, 2'b0}));
    aui_loop_error <= 1'b1;
    sel <= 3'h2;
    repeat (8) @(posedge pclk);
    chk(33'({la, lb, gla, glb}), 33'h0);
    rd(ADDR_STATUS, 33'h21C);
    apb(ADDR_OVR_RATE, 1'b1, 32'h3);
    apb(ADDR_OVR_CTRL, 1'b1, 32'h1);
    for (int r = 3; r >= 0; r--) begin
      apb(ADDR_OVR_RATE, 1'b1, 32'(r));
      repeat (2) @(posedge pclk);
      if (r == 0 || r == 3) chk(33'({la, gla, lb}), r == 3 ? 33'h7E0 : 33'h0);
    end
    apb(ADDR_OVR_CTRL, 1'b1, 32'h0);
    sel <= 3'h1;
    partitioned <= '0;
    repeat (8) @(posedge pclk);
    carrier[3] <= 1'b1;
    @(posedge pclk);
    carrier[3] <= 1'b0;
    repeat (30 * TC) @(posedge pclk);
    chk(33'({lb[3], gla}), 33'h3);
    repeat (20 * TC) @(posedge pclk);
    chk(33'({lb[3], gla}), 33'h0);
    port_disabled <= 5'h12;
    sel <= 3'h6;
    repeat (8) @(posedge pclk);
    chk(33'({la, lb}), 33'h52);
    sel <= 3'h7;
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (12) @(posedge pclk);
    chk(33'({la, lb, gla, glb}), 33'hFFF);
    $display("LED test done");
    tally_and_finish();
  end
endmodule
